// file: src/isl_core.sv
// Slotting unit and result latency scoreboard for the issue stage
`timescale 1ns/100ps
module isl_core (
  // Clock and reset
  input  logic                          clk_sys,
  input  logic                          reset_n,
  // Map stage fetch line
  input  isl_pkg::isl_inst_t      [3:0] line_i,
  output logic                    [3:0] slot_upper,
  output logic                          slot_valid,
  // Producer issue events
  input  isl_pkg::isl_issue_t           iss_i,
  // Consumer readiness query
  input  isl_pkg::isl_query_t           qry_i,
  output logic                    [1:0] src_ready,
  output logic                          issue_ok,
  output logic                          unit_busy
);
  import isl_pkg::*;

  // Whole module state
  typedef struct packed {
    isl_sb_t [ISL_NREG-1:0] sb;         // Scoreboard entries
    logic [ISL_CNT_W-1:0]   unit_cnt;   // Divide/sqrt reuse countdown
    logic [3:0]             slot_upper; // Registered slot decision
    logic                   slot_valid; // Line present last cycle
    logic [1:0]             src_ready;  // Per-source readiness
    logic                   issue_ok;   // Consumer may issue
    logic                   unit_busy;  // Unit not yet reusable
  } isl_state_t;

  isl_state_t           st_r;    // Registered state
  isl_state_t           st_nxt;  // Next state
  isl_lat_t             lat_w;   // Latency of issuing class
  isl_sclass_t [3:0]    cls_w;   // Side class per lane
  logic [3:0]           upper_w; // Combinational slot result
  logic                 ra_w;    // First source ready
  logic                 rb_w;    // Second source ready
  logic                 ufree_w; // Unit available to consumer

  // Slotting lookup
  isl_slot u_slot (
    .line       (line_i),
    .lane_cls   (cls_w),
    .lane_upper (upper_w)
  );

  // Latency of the class being issued
  isl_lat u_lat (
    .iss (iss_i),
    .lat (lat_w)
  );

  // Float store and float-to-integer consumers need the full count
  function automatic logic strict_use(input isl_class_t c);
    strict_use = (c == ISL_FST) || (c == ISL_FTOI);
  endfunction

  // Whether one source entry is ready for this consumer
  function automatic logic src_ok(input isl_sb_t e, input isl_query_t q);
    logic strict;
    strict = e.isflt ? strict_use(q.cls) : (e.upper != q.upper);
    // Strict consumers wait for zero, others only to the margin
    src_ok = strict ? (e.cnt == '0) : (e.cnt <= 6'(e.slack));
  endfunction

  // Whether a class needs the divide/sqrt unit
  function automatic logic uses_unit(input isl_class_t c);
    uses_unit = (c == ISL_FDIV) || (c == ISL_FSQRT);
  endfunction

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    ra_w   = src_ok(st_r.sb[qry_i.src_a], qry_i);
    rb_w   = !qry_i.use_b || src_ok(st_r.sb[qry_i.src_b], qry_i);
    // Unit is free once its reuse count has run out
    ufree_w = !uses_unit(qry_i.cls) || (st_r.unit_cnt == '0);
    // Every busy entry counts down one per cycle
    for (int i = 0; i < ISL_NREG; i++) begin
      if (st_r.sb[i].cnt != '0) begin
        st_nxt.sb[i].cnt = st_r.sb[i].cnt - 6'h01;
      end
    end
    // Reuse countdown of the divide/sqrt unit
    if (st_r.unit_cnt != '0) begin
      st_nxt.unit_cnt = st_r.unit_cnt - 6'h01;
    end
    // A producer overwrites its entry; renaming makes this safe
    if (iss_i.valid && lat_w.prod) begin
      st_nxt.sb[iss_i.dest].cnt   = lat_w.total - 6'h01;
      st_nxt.sb[iss_i.dest].slack = lat_w.slack;
      st_nxt.sb[iss_i.dest].isflt = lat_w.isflt;
      st_nxt.sb[iss_i.dest].upper = iss_i.upper;
    end
    // Starting a divide or root blocks the unit for its reuse time
    if (iss_i.valid && lat_w.unit) begin
      st_nxt.unit_cnt = lat_w.reuse - 6'h01;
    end
    // Answer to the query, one cycle later
    st_nxt.src_ready = {rb_w, ra_w};
    st_nxt.issue_ok  = qry_i.valid && ra_w && rb_w && ufree_w;
    st_nxt.unit_busy = (st_nxt.unit_cnt != '0);
    // Map stage result, registered for timing
    st_nxt.slot_upper = upper_w;
    st_nxt.slot_valid = line_i[0].valid || line_i[1].valid || line_i[2].valid || line_i[3].valid;
  end

  // State register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign slot_upper = st_r.slot_upper;
  assign slot_valid = st_r.slot_valid;
  assign src_ready  = st_r.src_ready;
  assign issue_ok   = st_r.issue_ok;
  assign unit_busy  = st_r.unit_busy;

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // Issue of a given class
  sequence s_iss(isl_class_t c);
    iss_i.valid && (iss_i.cls == c);
  endsequence

  // Single precision divide start
  sequence s_div_single;
    s_iss(ISL_FDIV) ##0 !iss_i.dbl;
  endsequence

  // Double precision root start
  sequence s_sqrt_double;
    s_iss(ISL_FSQRT) ##0 iss_i.dbl;
  endsequence

  // Integer load hit counts 3, then consumer sees zero
  a_int_load_hit: assert property (
    s_iss(ISL_ILD) ##0 !iss_i.dc_miss |=>
      (st_r.sb[$past(iss_i.dest)].cnt == 6'h02) ##2 (st_r.sb[$past(iss_i.dest, 3)].cnt == 6'h00))
    else $error("integer load hit latency wrong");

  // Integer load miss
  a_int_load_miss: assert property (
    s_iss(ISL_ILD) ##0 iss_i.dc_miss |=>
      st_r.sb[$past(iss_i.dest)].cnt == 6'h0c + 6'($past(iss_i.bc_extra)))
    else $error("integer load miss latency wrong");

  // Float load hit
  a_flt_load_hit: assert property (
    s_iss(ISL_FLD) ##0 !iss_i.dc_miss |=> st_r.sb[$past(iss_i.dest)].cnt == 6'h03)
    else $error("float load hit latency wrong");

  // Add result with cross-cluster margin
  a_alu_margin: assert property (
    s_iss(ISL_IADD) |=> (st_r.sb[$past(iss_i.dest)].cnt == 6'h01) && (st_r.sb[$past(iss_i.dest)].slack == 2'h1))
    else $error("add latency or margin wrong");

  // First conditional-move half
  a_cmov_first: assert property (
    s_iss(ISL_INT_COND_MOVE_FIRST) |=> st_r.sb[$past(iss_i.dest)].cnt == 6'h01)
    else $error("conditional move half latency wrong");

  // Multiply latency
  a_imul_lat: assert property (
    s_iss(ISL_IMUL) |=> st_r.sb[$past(iss_i.dest)].cnt == 6'h07)
    else $error("multiply latency wrong");

  // Slow privileged read
  a_priv_slow: assert property (
    s_iss(ISL_PRIV_RD) ##0 iss_i.priv_slow |=> st_r.sb[$past(iss_i.dest)].cnt == 6'h02)
    else $error("privileged read latency wrong");

  // Non-producers leave an idle entry idle
  a_no_producer: assert property (
    iss_i.valid && (iss_i.cls inside {ISL_IST, ISL_FST, ISL_IBR, ISL_UBR, ISL_FBR, ISL_NOP, ISL_PRIV_WR})
      && (st_r.sb[iss_i.dest].cnt == 6'h00) |=> st_r.sb[$past(iss_i.dest)].cnt == 6'h00)
    else $error("non-producer marked busy");

  // Float add: 6 to strict consumers, 4 to others
  a_fadd_store: assert property (
    s_iss(ISL_FADD) |=> (st_r.sb[$past(iss_i.dest)].cnt == 6'h05) && (st_r.sb[$past(iss_i.dest)].slack == 2'h2))
    else $error("float add latency wrong");

  // Second float move half
  a_fcmov_second: assert property (
    s_iss(ISL_FLOAT_COND_MOVE_SECOND) |=> st_r.sb[$past(iss_i.dest)].slack == 2'h2)
    else $error("float move second half margin wrong");

  // Divider busy for 8 cycles after a single precision start
  a_div_reuse: assert property (
    s_div_single |=> unit_busy [*8] ##1 !unit_busy)
    else $error("divider reuse time wrong");

  // Root unit reuse in double precision
  a_sqrt_reuse: assert property (
    s_sqrt_double |=> st_r.unit_cnt == 6'h1d)
    else $error("square root reuse time wrong");

  // Busy source holds the consumer
  a_consumer_hold: assert property (
    qry_i.valid && (st_r.sb[qry_i.src_a].cnt > 6'h02) |=> !issue_ok)
    else $error("consumer released early");

  // Fixed sides keep their side
  for (genvar g = 0; g < 4; g++) begin : g_side
    a_side_kept: assert property (
      line_i[g].valid && (cls_w[g] != ISL_SC_E) |=> slot_upper[g] == $past(cls_w[g] == ISL_SC_U))
      else $error("fixed side not kept");
  end
endmodule

// file: src/isl_pkg.sv
// Types and constants for integer slotting and result latency tracking
// Summary of operation
// - Map stage slots either-side ops by line mix
// - Classify each op upper, lower or either
// - Line position comes from PC bits 3:2
// - Fixed table maps class pattern to slots
// - Issue waits on operands and free units
// - Producer overwrites entry; no producer-producer ordering
// - Integer load 3 hit, 13 plus extra miss
// - Float load 4 hit, 14 plus extra miss
// - Add, logic, shift 1, plus cross-cluster cycle
// - Integer move halves 1 each, cross-cluster possible
// - Multiply 7, misc 3, plus cross-cluster cycle
// - Privileged read 1 or 3; write no result
// - Branches, stores and no-ops produce nothing
// - Float add 4, or 6 to store/transfer
// - Float multiply 4, or 6 to store/transfer
// - Float move halves 4; second gives 6
// - Divide result 12/15, reuse 9/12 cycles
// - Square root result 18/33, reuse 15/30
// - Shift class slots upper only
// - Integer loads slot lower only
package isl_pkg;
  // Sizes
  localparam int ISL_NREG   = 64; // Scoreboard entries
  localparam int ISL_TAG_W  = 6;  // Register tag width
  localparam int ISL_CNT_W  = 6;  // Countdown width
  localparam int ISL_POS_HI = 3;  // Line position, high PC bit
  localparam int ISL_POS_LO = 2;  // Line position, low PC bit
  // Result latencies in cycles
  localparam logic [5:0] ISL_LAT_ILD_HIT   = 6'h03;
  localparam logic [5:0] ISL_LAT_ILD_MISS  = 6'h0d;
  localparam logic [5:0] ISL_LAT_FLD_HIT   = 6'h04;
  localparam logic [5:0] ISL_LAT_FLD_MISS  = 6'h0e;
  localparam logic [5:0] ISL_LAT_ALU       = 6'h01;
  localparam logic [5:0] ISL_LAT_IMUL      = 6'h07;
  localparam logic [5:0] ISL_LAT_IMISC     = 6'h03;
  localparam logic [5:0] ISL_LAT_PRIV_FAST = 6'h01;
  localparam logic [5:0] ISL_LAT_PRIV_SLOW = 6'h03;
  localparam logic [5:0] ISL_LAT_JSR       = 6'h03;
  localparam logic [5:0] ISL_LAT_FLT       = 6'h04;
  localparam logic [5:0] ISL_LAT_FLT_STORE = 6'h06;
  localparam logic [5:0] ISL_LAT_FTOI      = 6'h03;
  localparam logic [5:0] ISL_LAT_ITOF      = 6'h04;
  localparam logic [5:0] ISL_LAT_FDIV_S    = 6'h0c;
  localparam logic [5:0] ISL_LAT_FDIV_D    = 6'h0f;
  localparam logic [5:0] ISL_RU_FDIV_S     = 6'h09;
  localparam logic [5:0] ISL_RU_FDIV_D     = 6'h0c;
  localparam logic [5:0] ISL_LAT_FSQRT_S   = 6'h12;
  localparam logic [5:0] ISL_LAT_FSQRT_D   = 6'h21;
  localparam logic [5:0] ISL_RU_FSQRT_S    = 6'h0f;
  localparam logic [5:0] ISL_RU_FSQRT_D    = 6'h1e;
  localparam logic [1:0] ISL_XC_DELAY      = 2'h1; // Cross-cluster penalty
  // Instruction classes
  typedef enum logic [4:0] {
    ISL_ILD = 5'h00, ISL_FLD = 5'h01, ISL_IST = 5'h02, ISL_FST = 5'h03,
    ISL_LDA = 5'h04, ISL_MEM_MISC = 5'h05, ISL_RPCC = 5'h06, ISL_RX = 5'h07,
    ISL_PRIV_RD = 5'h08, ISL_PRIV_WR = 5'h09, ISL_IBR = 5'h0a, ISL_UBR = 5'h0b,
    ISL_JSR = 5'h0c, ISL_IADD = 5'h0d, ISL_ILOG = 5'h0e, ISL_ISHF = 5'h0f,
    ISL_INT_COND_MOVE_FIRST = 5'h10, ISL_INT_COND_MOVE_SECOND = 5'h11,
    ISL_IMUL = 5'h12, ISL_IMISC = 5'h13, ISL_FBR = 5'h14, ISL_FADD = 5'h15,
    ISL_FMUL = 5'h16, ISL_FLOAT_COND_MOVE_FIRST = 5'h17,
    ISL_FLOAT_COND_MOVE_SECOND = 5'h18, ISL_FDIV = 5'h19, ISL_FSQRT = 5'h1a,
    ISL_NOP = 5'h1b, ISL_FTOI = 5'h1c, ISL_ITOF = 5'h1d, ISL_MX_FPCR = 5'h1e
  } isl_class_t;
  // Slotting side codes
  typedef enum logic [1:0] {
    ISL_SC_E = 2'h0, ISL_SC_L = 2'h1, ISL_SC_U = 2'h2
  } isl_sclass_t;
  // Slot table: index pattern base 3 (E=0,L=1,U=2), slot 3 most significant;
  // entry bit p set means position p goes upper
  localparam logic [0:80][3:0] ISL_SLOT_LUT =
    324'haa99c9aa3aa9989aa35655c5667565545663323101323565545667aa99c9aabaa9989aabccdccdeef;
  // One fetch-line lane
  typedef struct packed {
    logic       valid;  // Lane holds an instruction
    logic [3:0] pc_low; // Low program counter bits
    isl_class_t cls;    // Instruction class
  } isl_inst_t;
  // Producer issue event
  typedef struct packed {
    logic                 valid;    // Issue this cycle
    isl_class_t           cls;      // Producer class
    logic [ISL_TAG_W-1:0] dest;     // Destination tag
    logic                 upper;    // Issued in upper cluster
    logic                 dc_miss;  // Load missed primary cache
    logic [3:0]           bc_extra; // Extra board cache cycles
    logic                 dbl;      // Double precision
    logic                 priv_slow; // Slow internal_processor_register
  } isl_issue_t;
  // Consumer readiness query
  typedef struct packed {
    logic                 valid; // Query this cycle
    isl_class_t           cls;   // Consumer class
    logic [ISL_TAG_W-1:0] src_a; // First source tag
    logic [ISL_TAG_W-1:0] src_b; // Second source tag
    logic                 use_b; // Second source in use
    logic                 upper; // Consumer cluster
  } isl_query_t;
  // Latency record of a class
  typedef struct packed {
    logic                 prod;  // Writes a register
    logic [ISL_CNT_W-1:0] total; // Cycles to worst consumer
    logic [1:0]           slack; // Cycles earlier for plain consumer
    logic                 isflt; // Float producer
    logic                 unit;  // Uses divide/sqrt unit
    logic [ISL_CNT_W-1:0] reuse; // Unit reuse cycles
  } isl_lat_t;
  // Scoreboard entry
  typedef struct packed {
    logic [ISL_CNT_W-1:0] cnt;   // Cycles left to worst consumer
    logic [1:0]           slack; // Plain consumer margin
    logic                 isflt; // Float producer
    logic                 upper; // Producer cluster
  } isl_sb_t;
endpackage

// file: src/isl_slot.sv
// Combinational slotting of one fetch line to upper or lower subclusters
`timescale 1ns/100ps
module isl_slot (
  // Fetch line
  input  isl_pkg::isl_inst_t   [3:0] line,
  // Per-lane results
  output isl_pkg::isl_sclass_t [3:0] lane_cls,
  output logic                 [3:0] lane_upper
);
  import isl_pkg::*;

  // Side constraint of a class
  function automatic isl_sclass_t side_of(input isl_class_t c);
    case (c)
      ISL_IBR, ISL_ISHF, ISL_IMUL, ISL_IMISC: side_of = ISL_SC_U;
      ISL_ILD, ISL_FLD, ISL_IST, ISL_FST, ISL_MEM_MISC, ISL_RPCC, ISL_RX,
      ISL_PRIV_RD, ISL_PRIV_WR, ISL_JSR, ISL_FTOI, ISL_ITOF: side_of = ISL_SC_L;
      default: side_of = ISL_SC_E;
    endcase
  endfunction

  // Pattern build and table lookup, no state
  always_comb begin
    isl_sclass_t [3:0] pat;
    logic [6:0]        idx;
    logic [3:0]        sel;
    pat = '0;
    idx = '0;
    sel = '0;
    // Empty positions count as either
    for (int p = 0; p < 4; p++) begin
      pat[p] = ISL_SC_E;
    end
    for (int l = 0; l < 4; l++) begin
      lane_cls[l] = side_of(line[l].cls);
      if (line[l].valid) begin
        pat[line[l].pc_low[ISL_POS_HI:ISL_POS_LO]] = lane_cls[l];
      end
    end
    idx = 7'(pat[3]) * 7'h1b + 7'(pat[2]) * 7'h09 + 7'(pat[1]) * 7'h03 + 7'(pat[0]);
    sel = ISL_SLOT_LUT[idx];
    // Each lane picks its position's side
    for (int l = 0; l < 4; l++) begin
      lane_upper[l] = sel[line[l].pc_low[ISL_POS_HI:ISL_POS_LO]];
    end
  end
endmodule

// file: src/isl_lat.sv
// Class to result latency and unit reuse lookup
`timescale 1ns/100ps
module isl_lat (
  // Producer being issued
  input  isl_pkg::isl_issue_t iss,
  // Latency record
  output isl_pkg::isl_lat_t   lat
);
  import isl_pkg::*;

  // Integer result with a possible cross-cluster cycle
  function automatic isl_lat_t int_xc(input logic [5:0] base);
    int_xc       = '0;
    int_xc.prod  = 1'b1;
    int_xc.total = base + 6'(ISL_XC_DELAY);
    int_xc.slack = ISL_XC_DELAY;
  endfunction

  // Result with one fixed latency
  function automatic isl_lat_t fixed(input logic [5:0] t, input logic f);
    fixed       = '0;
    fixed.prod  = 1'b1;
    fixed.total = t;
    fixed.isflt = f;
  endfunction

  // Float result, later for store or float-to-integer consumers
  function automatic isl_lat_t flt_st(input logic dummy);
    flt_st       = fixed(ISL_LAT_FLT_STORE, 1'b1);
    flt_st.slack = 2'(ISL_LAT_FLT_STORE - ISL_LAT_FLT);
  endfunction

  // Class decode
  always_comb begin
    lat = '0;
    case (iss.cls)
      ISL_ILD: lat = fixed(iss.dc_miss ? ISL_LAT_ILD_MISS + 6'(iss.bc_extra) : ISL_LAT_ILD_HIT, 1'b0);
      ISL_FLD: lat = fixed(iss.dc_miss ? ISL_LAT_FLD_MISS + 6'(iss.bc_extra) : ISL_LAT_FLD_HIT, 1'b1);
      ISL_LDA, ISL_IADD, ISL_ILOG, ISL_ISHF: lat = int_xc(ISL_LAT_ALU);
      ISL_INT_COND_MOVE_FIRST, ISL_INT_COND_MOVE_SECOND: lat = int_xc(ISL_LAT_ALU);
      ISL_IMUL: lat = int_xc(ISL_LAT_IMUL);
      ISL_IMISC: lat = int_xc(ISL_LAT_IMISC);
      ISL_RPCC, ISL_RX: lat = fixed(ISL_LAT_ALU, 1'b0);
      ISL_PRIV_RD: lat = fixed(iss.priv_slow ? ISL_LAT_PRIV_SLOW : ISL_LAT_PRIV_FAST, 1'b0);
      ISL_JSR: lat = fixed(ISL_LAT_JSR, 1'b0);
      ISL_FADD, ISL_FMUL: lat = flt_st(1'b0);
      ISL_FLOAT_COND_MOVE_FIRST: lat = fixed(ISL_LAT_FLT, 1'b1);
      ISL_FLOAT_COND_MOVE_SECOND: lat = flt_st(1'b0);
      ISL_FDIV: begin
        lat       = fixed(iss.dbl ? ISL_LAT_FDIV_D : ISL_LAT_FDIV_S, 1'b1);
        lat.unit  = 1'b1;
        lat.reuse = iss.dbl ? ISL_RU_FDIV_D : ISL_RU_FDIV_S;
      end
      ISL_FSQRT: begin
        lat       = fixed(iss.dbl ? ISL_LAT_FSQRT_D : ISL_LAT_FSQRT_S, 1'b1);
        lat.unit  = 1'b1;
        lat.reuse = iss.dbl ? ISL_RU_FSQRT_D : ISL_RU_FSQRT_S;
      end
      ISL_FTOI: lat = fixed(ISL_LAT_FTOI, 1'b0);
      ISL_ITOF, ISL_MX_FPCR: lat = fixed(ISL_LAT_ITOF, 1'b1);
      // Stores, branches, no-ops, privileged writes, memory misc
      default: lat = '0;
    endcase
  end
endmodule

// file: verif/isl_iq_model.sv
// Issue-queue model: issues one producer, then polls one consumer until it may go
`timescale 1ns/100ps
module isl_queue_model (
  // Clock
  input  wire logic           clk_sys,
  // Requests from the bench
  input  wire logic           start,
  input  isl_pkg::isl_issue_t iss_req,
  input  isl_pkg::isl_query_t qry_req,
  // Answer from the block
  input  wire logic           issue_ok,
  input  wire logic [1:0]     src_ready,
  // Drive into the block
  output isl_pkg::isl_issue_t iss_o,
  output isl_pkg::isl_query_t qry_o,
  // Measured wait
  output logic [7:0]          waited,
  output logic                done,
  // Source readiness seen on the first poll
  output logic [1:0]          first_rdy
);
  import isl_pkg::*;
  // One transfer per start; drives change on falling edges, waited counts on rising edges
  initial begin
    iss_o = '0;
    qry_o = '0;
    waited = 8'h00;
    done = 1'h0;
    first_rdy = 2'h0;
    forever begin
      @(posedge start);
      done = 1'h0;
      iss_o = iss_req;
      @(negedge clk_sys);
      // Issue is a one-cycle event
      iss_o = '0;
      qry_o = qry_req;
      waited = 8'h00;
      // Count edges until the consumer may go; bounded so a hang shows as a bad count
      do begin
        @(posedge clk_sys);
        waited = waited + 8'h01;
        @(negedge clk_sys);
        // Keep the first answer; later polls may already be ready
        if (waited == 8'h01) begin
          first_rdy = src_ready;
        end
      end while (issue_ok !== 1'h1 && waited < 8'h3c);
      // Query released once answered
      qry_o = '0;
      done = 1'h1;
    end
  end
endmodule

// file: verif/isl_core_tb.sv
// Self-checking bench for slotting and result latency
`timescale 1ns/100ps
module isl_core_tb;
  import isl_pkg::*;
  logic                  clk_sys;   // System clock
  logic                  reset_n;   // Async reset
  isl_inst_t       [3:0] line_i;    // Fetch line
  logic            [3:0] slot_upper;
  logic                  slot_valid;
  isl_issue_t            iss_i;     // From model
  isl_query_t            qry_i;     // From model
  logic            [1:0] src_ready;
  logic                  issue_ok;
  logic                  unit_busy;
  isl_issue_t            iss_req;   // Model request
  isl_query_t            qry_req;
  logic                  start;
  logic            [7:0] waited;
  logic                  done;
  logic            [1:0] first_rdy; // Readiness at first poll
  int                    err_total;
  int                    total_checks;
  int                    cyc;       // Watchdog count
  // Device under test
  isl_core i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .line_i(line_i), .slot_upper(slot_upper),
    .slot_valid(slot_valid), .iss_i(iss_i), .qry_i(qry_i), .src_ready(src_ready),
    .issue_ok(issue_ok), .unit_busy(unit_busy));
  // Far-side issue queue
  isl_queue_model i_queue (.clk_sys(clk_sys), .start(start), .iss_req(iss_req), .qry_req(qry_req),
    .issue_ok(issue_ok), .src_ready(src_ready), .iss_o(iss_i), .qry_o(qry_i), .waited(waited),
    .done(done), .first_rdy(first_rdy));
  // Clock, 20 ns period
  always #10 clk_sys = ~clk_sys;
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Counts, verdict and end of run
  task automatic give_verdict;
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog; a whole run needs well under 2000 cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict;
    end
  end
  // Producer on register 5 with flags {miss, double, slow}
  function automatic isl_issue_t mi(isl_class_t c, logic u, logic [2:0] f, logic [3:0] b);
    mi = '{valid:1'h1, cls:c, dest:6'h05, upper:u, dc_miss:f[2], bc_extra:b, dbl:f[1], priv_slow:f[0]};
  endfunction
  // Issue, poll a consumer of source s, compare the wait in cycles
  task automatic run(input isl_issue_t i, input isl_class_t qc, input logic qu, input logic [5:0] s,
    input logic [7:0] exp);
    int k;
    iss_req = i;
    qry_req = '{valid:1'h1, cls:qc, src_a:s, src_b:6'h00, use_b:1'h0, upper:qu};
    start = 1'h1;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (done !== 1'h1 && k < 80);
    start = 1'h0;
    check(waited, exp);
    // Producer writes register 5; unused second source always reads ready
    check({6'h0, first_rdy}, {6'h0, 1'h1, (s != 6'h05) || (exp == 8'h01)});
    @(negedge clk_sys);
  endtask
  // Letter to a class of that slotting side
  function automatic isl_class_t cc(byte c);
    cc = (c == "U") ? ISL_ISHF : (c == "L") ? ISL_ILD : ISL_IADD;
  endfunction
  // Outputs quiet in reset; just after, only the two source ready bits rise
  task automatic t_reset;
    check({3'h0, slot_valid, issue_ok, unit_busy, src_ready}, 8'h00);
    reset_n = 1'h1;
    @(negedge clk_sys);
    // Idle query still reads register 0, which is ready, so both source bits rise
    check({3'h0, slot_valid, issue_ok, unit_busy, src_ready}, 8'h03);
  endtask
  // Lanes hold reversed positions, so lane order alone gives wrong answers
  task automatic t_slot;
    string cp [7] = '{"EEEE", "EELL", "EEUU", "LUEL", "UUUE", "ELLL", "EUEL"};
    string sp [7] = '{"ULUL", "UULL", "LLUU", "LUUL", "UUUL", "ULLL", "LUUL"};
    logic [3:0] e;
    for (int t = 0; t < 7; t++) begin
      for (int l = 0; l < 4; l++) begin
        line_i[l] = '{valid:1'h1, pc_low:{2'(3 - l), 2'h0}, cls:cc(cp[t][l])};
        e[l] = (sp[t][l] == "U");
      end
      @(negedge clk_sys);
      check({4'h0, slot_upper}, {4'h0, e});
      check({7'h0, slot_valid}, 8'h01);
    end
    line_i = '0;
    @(negedge clk_sys);
    check({7'h0, slot_valid}, 8'h00);
  endtask
  // Integer producers, same and other cluster
  task automatic t_int_lat;
    run(mi(ISL_ILD, 1'h0, 3'h0, 4'h0), ISL_ILD, 1'h0, 6'h05, 8'h03);
    run(mi(ISL_ILD, 1'h0, 3'h4, 4'h2), ISL_ILD, 1'h0, 6'h05, 8'h0f);
    run(mi(ISL_IADD, 1'h1, 3'h0, 4'h0), ISL_IADD, 1'h1, 6'h05, 8'h01);
    run(mi(ISL_ILOG, 1'h1, 3'h0, 4'h0), ISL_IADD, 1'h0, 6'h05, 8'h02);
    run(mi(ISL_ISHF, 1'h0, 3'h0, 4'h0), ISL_ILOG, 1'h0, 6'h05, 8'h01);
    run(mi(ISL_INT_COND_MOVE_FIRST, 1'h0, 3'h0, 4'h0), ISL_INT_COND_MOVE_SECOND, 1'h0, 6'h05, 8'h01);
    run(mi(ISL_INT_COND_MOVE_SECOND, 1'h0, 3'h0, 4'h0), ISL_IADD, 1'h1, 6'h05, 8'h02);
    run(mi(ISL_IMUL, 1'h1, 3'h0, 4'h0), ISL_IADD, 1'h1, 6'h05, 8'h07);
    run(mi(ISL_IMUL, 1'h1, 3'h0, 4'h0), ISL_IADD, 1'h0, 6'h05, 8'h08);
    run(mi(ISL_IMISC, 1'h1, 3'h0, 4'h0), ISL_IADD, 1'h1, 6'h05, 8'h03);
    run(mi(ISL_PRIV_RD, 1'h0, 3'h0, 4'h0), ISL_IADD, 1'h0, 6'h05, 8'h01);
    run(mi(ISL_PRIV_RD, 1'h0, 3'h1, 4'h0), ISL_IADD, 1'h0, 6'h05, 8'h03);
  endtask
  // Float producers, ordinary and store/transfer consumers
  task automatic t_flt_lat;
    run(mi(ISL_FLD, 1'h0, 3'h0, 4'h0), ISL_FADD, 1'h0, 6'h05, 8'h04);
    run(mi(ISL_FLD, 1'h0, 3'h4, 4'h0), ISL_FADD, 1'h0, 6'h05, 8'h0e);
    run(mi(ISL_FADD, 1'h0, 3'h0, 4'h0), ISL_FMUL, 1'h0, 6'h05, 8'h04);
    run(mi(ISL_FADD, 1'h0, 3'h0, 4'h0), ISL_FTOI, 1'h0, 6'h05, 8'h06);
    run(mi(ISL_FMUL, 1'h0, 3'h0, 4'h0), ISL_FADD, 1'h0, 6'h05, 8'h04);
    run(mi(ISL_FMUL, 1'h0, 3'h0, 4'h0), ISL_FST, 1'h0, 6'h05, 8'h06);
    run(mi(ISL_FLOAT_COND_MOVE_FIRST, 1'h0, 3'h0, 4'h0), ISL_FLOAT_COND_MOVE_SECOND, 1'h0, 6'h05, 8'h04);
    run(mi(ISL_FLOAT_COND_MOVE_SECOND, 1'h0, 3'h0, 4'h0), ISL_FST, 1'h0, 6'h05, 8'h06);
    run(mi(ISL_FDIV, 1'h0, 3'h0, 4'h0), ISL_FADD, 1'h0, 6'h05, 8'h0c);
    run(mi(ISL_FDIV, 1'h0, 3'h2, 4'h0), ISL_FADD, 1'h0, 6'h05, 8'h0f);
    run(mi(ISL_FSQRT, 1'h0, 3'h0, 4'h0), ISL_FADD, 1'h0, 6'h05, 8'h12);
    run(mi(ISL_FSQRT, 1'h0, 3'h2, 4'h0), ISL_FADD, 1'h0, 6'h05, 8'h21);
  endtask
  // Unit reuse: a divide-class consumer of a ready register waits for the unit only
  task automatic t_reuse;
    run(mi(ISL_FDIV, 1'h0, 3'h0, 4'h0), ISL_FDIV, 1'h0, 6'h07, 8'h09);
    run(mi(ISL_FDIV, 1'h0, 3'h2, 4'h0), ISL_FSQRT, 1'h0, 6'h07, 8'h0c);
    run(mi(ISL_FSQRT, 1'h0, 3'h0, 4'h0), ISL_FDIV, 1'h0, 6'h07, 8'h0f);
    run(mi(ISL_FSQRT, 1'h0, 3'h2, 4'h0), ISL_FSQRT, 1'h0, 6'h07, 8'h1e);
    check({7'h0, unit_busy}, 8'h00);
  endtask
  // Non-producers must leave register 5 ready
  task automatic t_no_result;
    isl_class_t np [7] = '{ISL_IST, ISL_FST, ISL_IBR, ISL_UBR, ISL_FBR, ISL_NOP, ISL_PRIV_WR};
    for (int n = 0; n < 7; n++) begin
      run(mi(np[n], 1'h0, 3'h0, 4'h0), ISL_IADD, 1'h0, 6'h05, 8'h01);
    end
  endtask
  // Main sequence
  initial begin
    clk_sys = 1'h0;
    reset_n = 1'h0;
    line_i = '0;
    start = 1'h0;
    iss_req = '0;
    qry_req = '0;
    err_total = 0;
    total_checks = 0;
    cyc = 0;
    repeat (3) @(negedge clk_sys);
    t_reset;
    t_slot;
    t_int_lat;
    t_flt_lat;
    t_reuse;
    t_no_result;
    give_verdict;
  end
endmodule
